// *** design/uecs_pkg.sv ***
// package: register map, field positions, reset values and timing constants for the endpoint control block
package uecs_pkg;
   localparam logic [31:0] DISC_TIMER_ADDR = 32'hF00E0014;
   localparam logic [31:0] EP0_STATUS_ADDR = 32'hF00E0018;
   localparam logic [31:0] EP1_STATUS_ADDR = 32'hF00E001C;
   localparam logic [31:0] DISC_TIMER_RESET = 32'h00000001;
   localparam logic [31:0] EP0_STATUS_RESET = 32'h00000001;
   localparam logic [31:0] EP1_STATUS_RESET = 32'h00000401;
   localparam int DISC_COUNT_W = 23;
   localparam int DISC_START_BIT = 31;
   localparam int DISC_EXP_OFFSET = 7;
   localparam int EP0_MAX_PACKET_CODE_W = 4;
   localparam int EP1_MAX_PACKET_CODE_W = 3;
   localparam int MAX_PACKET_CODE_SET_BIT = 7;
   localparam int EP0_EP0_OUT_READY_BIT = 24;
   localparam int EP0_EP0_IN_READY_BIT = 25;
   localparam int EP0_SENT_STALL_BIT = 26;
   localparam int EP0_EP0_DATA_END_BIT = 27;
   localparam int EP0_EP0_SETUP_END_BIT = 28;
   localparam int EP0_SEND_STALL_BIT = 29;
   localparam int EP0_SV_EP0_OUT_READY_BIT = 30;
   localparam int EP0_SV_EP0_SETUP_END_BIT = 31;
   localparam int EP1_MODE_LO = 8;
   localparam int EP1_MODE_HI = 12;
   localparam int EP1_OUT_ISOCHRONOUS_SELECT_BIT = 8;
   localparam int EP1_OUT_AUTO_CLEAR_BIT = 9;
   localparam int EP1_DIR_BIT = 10;
   localparam int EP1_IN_ISOCHRONOUS_SELECT_BIT = 11;
   localparam int EP1_IN_AUTO_SET_BIT = 12;
   localparam int EP1_MODE_SET_BIT = 15;
   localparam int EP1_EP0_OUT_READY_BIT = 16;
   localparam int EP1_OFULL_BIT = 17;
   localparam int EP1_OUT_OVERRUN_BIT = 18;
   localparam int EP1_OUT_DATA_ERROR_BIT = 19;
   localparam int EP1_OFLUSH_BIT = 20;
   localparam int EP1_OSEND_STALL_BIT = 21;
   localparam int EP1_OSENT_STALL_BIT = 22;
   localparam int EP1_OUT_CLEAR_TOGGLE_BIT = 23;
   localparam int EP1_IRDY_BIT = 24;
   localparam int EP1_IN_FIFO_NOT_EMPTY_BIT = 25;
   localparam int EP1_IN_UNDERRUN_BIT = 26;
   localparam int EP1_IFLUSH_BIT = 27;
   localparam int EP1_ISEND_STALL_BIT = 28;
   localparam int EP1_ISENT_STALL_BIT = 29;
   localparam int EP1_IN_CLEAR_TOGGLE_BIT = 30;
   // disconnect tick: 20.8333 ns, kept in ps to stay integer
   localparam int DISC_TICK_PS = 20833;
   localparam int CLK_PERIOD_PS = 10000;
   // usb-side events from the serial engine, all one-cycle pulses
   typedef struct packed {
      logic ep0_out_received;
      logic ep0_in_sent;
      logic ep0_protocol_stall;
      logic ep0_transfer_end;
      logic ep1_out_loaded;
      logic ep1_out_fifo_full;
      logic ep1_out_overrun;
      logic ep1_out_data_error;
      logic ep1_out_stalled;
      logic ep1_in_sent;
      logic ep1_in_token;
      logic ep1_token_busy;
   } uecs_evt_t;
   // processor-side fifo activity
   typedef struct packed {
      logic ep0_unload_last;
      logic ep1_unload_last;
      logic ep1_load_full_packet;
      logic ep1_load_word;
   } uecs_fifo_t;
   typedef enum logic [2:0] {
      DISC_IDLE = 3'b001,
      DISC_RUN = 3'b010,
      DISC_DONE = 3'b100
   } uecs_disc_state_t;
endpackage

// *** design/uecs_top.sv ***
// endpoint control/status registers and timed bus-disconnect engine
`timescale 1ns/1ps
`default_nettype none
module uecs_top
   import uecs_pkg::*;
#(
   parameter int TICK_PS = DISC_TICK_PS
)(
   input wire logic clk_sys, // system clock, 100 MHz
   input wire logic reset, // async reset, active high
   input wire logic [31:0] reg_addr, // register byte address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_write, // write strobe
   input wire logic reg_read, // read strobe
   output logic [31:0] reg_rdata, // read data, valid the cycle after the strobe
   input wire uecs_pkg::uecs_evt_t usb_evt, // serial engine event pulses
   input wire uecs_pkg::uecs_fifo_t fifo_evt, // processor fifo activity pulses
   output logic line_se0, // force both data lines low
   output logic disconnect_done_flag, // disconnect finished, cleared by writing zero
   output logic control_endpoint_interrupt_flag, // ep0 event sticky, read-clear
   output logic ep1_interrupt, // ep1 event pulse
   output logic ep0_stall_answer, // answer ep0 tokens with STALL
   output logic ep1_stall_answer, // answer ep1 tokens with STALL
   output logic ep0_fifo_flush, // pulse: discard ep0 fifo
   output logic ep0_fifo_blocked, // processor fifo access invalid
   output logic ep1_fifo_flush, // pulse: discard top ep1 packet
   output logic ep1_in_write_blocked, // processor may not write ep1 fifo
   output logic ep1_send_zero_length, // pulse: send zero-length packet
   output logic ep1_out_toggle, // out data toggle
   output logic ep1_in_toggle // in data toggle
);
   import uecs_pkg::*;

   localparam int CNT_W = 32;
   // tick period in clock cycles rounded to nearest, min one; exponent scales it
   localparam int TICK_CYC = ((TICK_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS) < 1 ? 1 :
      ((TICK_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS);

   logic wr_disc, wr_ep0, wr_ep1, rd_ep0;
   assign wr_disc = reg_write && (reg_addr == DISC_TIMER_ADDR);
   assign wr_ep0 = reg_write && (reg_addr == EP0_STATUS_ADDR);
   assign wr_ep1 = reg_write && (reg_addr == EP1_STATUS_ADDR);
   assign rd_ep0 = reg_read && (reg_addr == EP0_STATUS_ADDR);

   // disconnect engine
   uecs_disc_state_t disc_state_reg;
   logic [DISC_COUNT_W-1:0] disconnect_count_reg;
   logic [CNT_W+8:0] tick_total_reg;
   logic [CNT_W+8:0] tick_cnt_reg;
   logic [7:0] sub_cnt_reg;
   logic disc_done_reg;
   logic [5:0] exp_sat;

   // exponents above the counter width saturate; intervals that long are not testable anyway
   assign exp_sat = (disconnect_count_reg > (DISC_COUNT_W'(CNT_W - DISC_EXP_OFFSET))) ?
      6'(CNT_W) : 6'(disconnect_count_reg[5:0] + 6'(DISC_EXP_OFFSET));

   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
         disconnect_count_reg <= DISC_TIMER_RESET[DISC_COUNT_W-1:0];
      else if (wr_disc && disc_state_reg == DISC_IDLE)
         disconnect_count_reg <= reg_wdata[DISC_COUNT_W-1:0];

   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
      begin
         disc_state_reg <= DISC_IDLE;
         tick_cnt_reg <= '0;
         sub_cnt_reg <= '0;
      end
      else
      begin
         case (disc_state_reg)
            DISC_IDLE:
               if (wr_disc && reg_wdata[DISC_START_BIT])
               begin
                  disc_state_reg <= DISC_RUN;
                  tick_cnt_reg <= '0;
                  sub_cnt_reg <= '0;
               end
            DISC_RUN:
               if (sub_cnt_reg == 8'(TICK_CYC - 1))
               begin
                  sub_cnt_reg <= '0;
                  if (tick_cnt_reg == tick_total_reg - 1'b1)
                     disc_state_reg <= DISC_DONE;
                  tick_cnt_reg <= tick_cnt_reg + 1'b1;
               end
               else
                  sub_cnt_reg <= sub_cnt_reg + 1'b1;
            DISC_DONE:
               disc_state_reg <= DISC_IDLE;
            default:
               disc_state_reg <= DISC_IDLE;
         endcase
      end

   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
         tick_total_reg <= '0;
      else
         tick_total_reg <= (CNT_W+9)'(1) << exp_sat;

   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
         line_se0 <= 1'b0;
      else
         line_se0 <= (disc_state_reg == DISC_RUN);

   // set beats software clear
   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
         disc_done_reg <= 1'b0;
      else if (disc_state_reg == DISC_DONE)
         disc_done_reg <= 1'b1;
      else if (wr_disc && !reg_wdata[DISC_START_BIT])
         disc_done_reg <= 1'b0;
   assign disconnect_done_flag = disc_done_reg;

   // endpoint 0
   logic [EP0_MAX_PACKET_CODE_W-1:0] ep0_max_packet_code_reg;
   logic ep0_ep0_out_ready_reg, ep0_ep0_in_ready_reg, ep0_sstall_reg, ep0_ep0_data_end_reg, ep0_ep0_setup_end_reg, ep0_ep0_send_stall_reg;
   logic ep0_int_reg;

   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
         ep0_max_packet_code_reg <= EP0_STATUS_RESET[EP0_MAX_PACKET_CODE_W-1:0];
      else if (wr_ep0 && reg_wdata[MAX_PACKET_CODE_SET_BIT])
         ep0_max_packet_code_reg <= reg_wdata[EP0_MAX_PACKET_CODE_W-1:0];

   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
      begin
         ep0_ep0_out_ready_reg <= 1'b0;
         ep0_ep0_in_ready_reg <= 1'b0;
         ep0_sstall_reg <= 1'b0;
         ep0_ep0_data_end_reg <= 1'b0;
         ep0_ep0_setup_end_reg <= 1'b0;
         ep0_ep0_send_stall_reg <= 1'b0;
      end
      else
      begin
         if (usb_evt.ep0_out_received)
            ep0_ep0_out_ready_reg <= 1'b1;
         else if (wr_ep0 && reg_wdata[EP0_SV_EP0_OUT_READY_BIT])
            ep0_ep0_out_ready_reg <= 1'b0;
         if (usb_evt.ep0_in_sent)
            ep0_ep0_in_ready_reg <= 1'b0;
         else if (wr_ep0 && reg_wdata[EP0_EP0_IN_READY_BIT])
            ep0_ep0_in_ready_reg <= 1'b1;
         if (usb_evt.ep0_protocol_stall)
            ep0_sstall_reg <= 1'b1;
         else if (wr_ep0 && !reg_wdata[EP0_SENT_STALL_BIT])
            ep0_sstall_reg <= 1'b0;
         if (wr_ep0 && reg_wdata[EP0_EP0_DATA_END_BIT])
            ep0_ep0_data_end_reg <= 1'b1;
         else if (usb_evt.ep0_transfer_end)
            ep0_ep0_data_end_reg <= 1'b0;
         if (usb_evt.ep0_transfer_end && !ep0_ep0_data_end_reg)
            ep0_ep0_setup_end_reg <= 1'b1;
         else if (wr_ep0 && reg_wdata[EP0_SV_EP0_SETUP_END_BIT])
            ep0_ep0_setup_end_reg <= 1'b0;
         if (wr_ep0)
            ep0_ep0_send_stall_reg <= reg_wdata[EP0_SEND_STALL_BIT];
      end

   // sticky until software reads the ep0 status register; set wins over the read
   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
         ep0_int_reg <= 1'b0;
      else if (usb_evt.ep0_out_received || usb_evt.ep0_in_sent || usb_evt.ep0_protocol_stall ||
               (usb_evt.ep0_transfer_end && (ep0_ep0_data_end_reg || !ep0_ep0_setup_end_reg)))
         ep0_int_reg <= 1'b1;
      else if (rd_ep0)
         ep0_int_reg <= 1'b0;
   assign control_endpoint_interrupt_flag = ep0_int_reg;

   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
      begin
         ep0_stall_answer <= 1'b0;
         ep0_fifo_flush <= 1'b0;
         ep0_fifo_blocked <= 1'b0;
      end
      else
      begin
         ep0_stall_answer <= ep0_ep0_send_stall_reg;
         ep0_fifo_flush <= usb_evt.ep0_transfer_end && !ep0_ep0_data_end_reg;
         ep0_fifo_blocked <= ep0_ep0_setup_end_reg;
      end

   // endpoint 1
   logic [EP1_MAX_PACKET_CODE_W-1:0] ep1_max_packet_code_reg;
   logic [EP1_MODE_HI-EP1_MODE_LO:0] ep1_mode_reg;
   logic o_rdy_reg, o_full_reg, o_over_reg, o_derr_reg, o_derr_pend_reg, o_flush_reg;
   logic o_ep0_send_stall_reg, o_ep0_sent_stall_reg, i_rdy_reg, i_nemp_reg, i_under_reg, i_flush_reg;
   logic i_ep0_send_stall_reg, i_ep0_sent_stall_reg, i_drop_next_reg, ep1_int_next;
   logic is_out, out_iso, in_iso, in_stall_hit, in_flush_go, i_rdy_manual;

   assign is_out = !ep1_mode_reg[EP1_DIR_BIT-EP1_MODE_LO];
   assign out_iso = is_out && ep1_mode_reg[EP1_OUT_ISOCHRONOUS_SELECT_BIT-EP1_MODE_LO];
   assign in_iso = !is_out && ep1_mode_reg[EP1_IN_ISOCHRONOUS_SELECT_BIT-EP1_MODE_LO];
   assign in_stall_hit = usb_evt.ep1_in_token && i_ep0_send_stall_reg;
   assign in_flush_go = i_flush_reg && !usb_evt.ep1_token_busy;
   assign i_rdy_manual = wr_ep1 && reg_wdata[EP1_IRDY_BIT] && !i_ep0_send_stall_reg;

   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
      begin
         ep1_max_packet_code_reg <= EP1_STATUS_RESET[EP1_MAX_PACKET_CODE_W-1:0];
         ep1_mode_reg <= EP1_STATUS_RESET[EP1_MODE_HI:EP1_MODE_LO];
      end
      else
      begin
         if (wr_ep1 && reg_wdata[MAX_PACKET_CODE_SET_BIT])
            ep1_max_packet_code_reg <= reg_wdata[EP1_MAX_PACKET_CODE_W-1:0];
         if (wr_ep1 && reg_wdata[EP1_MODE_SET_BIT])
            ep1_mode_reg <= reg_wdata[EP1_MODE_HI:EP1_MODE_LO];
      end

   // out direction flags
   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
      begin
         o_rdy_reg <= 1'b0;
         o_full_reg <= 1'b0;
         o_over_reg <= 1'b0;
         o_derr_reg <= 1'b0;
         o_derr_pend_reg <= 1'b0;
         o_flush_reg <= 1'b0;
         o_ep0_send_stall_reg <= 1'b0;
         o_ep0_sent_stall_reg <= 1'b0;
      end
      else
      begin
         if (usb_evt.ep1_out_loaded && is_out)
            o_rdy_reg <= 1'b1;
         else if ((wr_ep1 && !reg_wdata[EP1_EP0_OUT_READY_BIT]) || o_flush_reg ||
                  (fifo_evt.ep1_unload_last && ep1_mode_reg[EP1_OUT_AUTO_CLEAR_BIT-EP1_MODE_LO]))
            o_rdy_reg <= o_full_reg;
         if (usb_evt.ep1_out_loaded && o_rdy_reg)
            o_full_reg <= usb_evt.ep1_out_fifo_full;
         else if (!o_rdy_reg || o_flush_reg || (wr_ep1 && !reg_wdata[EP1_EP0_OUT_READY_BIT]))
            o_full_reg <= 1'b0;
         if (usb_evt.ep1_out_overrun && out_iso)
            o_over_reg <= 1'b1;
         else if (wr_ep1 && !reg_wdata[EP1_OUT_OVERRUN_BIT])
            o_over_reg <= 1'b0;
         // a second packet's error waits until the first is unloaded
         if (usb_evt.ep1_out_data_error && out_iso && o_rdy_reg)
            o_derr_pend_reg <= 1'b1;
         else if (!o_rdy_reg)
            o_derr_pend_reg <= 1'b0;
         if (usb_evt.ep1_out_data_error && out_iso && !o_rdy_reg)
            o_derr_reg <= 1'b1;
         else if (!o_rdy_reg)
            o_derr_reg <= 1'b0;
         else if (o_derr_pend_reg && !o_full_reg)
            o_derr_reg <= 1'b1;
         if (o_flush_reg)
            o_flush_reg <= 1'b0;
         else if (wr_ep1 && reg_wdata[EP1_OFLUSH_BIT] && o_rdy_reg)
            o_flush_reg <= 1'b1;
         if (wr_ep1)
            o_ep0_send_stall_reg <= reg_wdata[EP1_OSEND_STALL_BIT];
         if (usb_evt.ep1_out_stalled)
            o_ep0_sent_stall_reg <= 1'b1;
         else if (wr_ep1 && !reg_wdata[EP1_OSENT_STALL_BIT])
            o_ep0_sent_stall_reg <= 1'b0;
      end

   // in direction flags
   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
      begin
         i_rdy_reg <= 1'b0;
         i_nemp_reg <= 1'b0;
         i_under_reg <= 1'b0;
         i_flush_reg <= 1'b0;
         i_ep0_send_stall_reg <= 1'b0;
         i_ep0_sent_stall_reg <= 1'b0;
         i_drop_next_reg <= 1'b0;
      end
      else
      begin
         if (usb_evt.ep1_in_sent || in_stall_hit || in_flush_go)
            i_rdy_reg <= 1'b0;
         else if (i_rdy_manual ||
                  (fifo_evt.ep1_load_full_packet && ep1_mode_reg[EP1_IN_AUTO_SET_BIT-EP1_MODE_LO] && !i_ep0_send_stall_reg))
            i_rdy_reg <= 1'b1;
         if (fifo_evt.ep1_load_word && !i_rdy_reg)
            i_nemp_reg <= 1'b1;
         else if (usb_evt.ep1_in_sent || in_flush_go)
            i_nemp_reg <= 1'b0;
         if (usb_evt.ep1_in_token && in_iso && !i_rdy_reg)
            i_under_reg <= 1'b1;
         else if (wr_ep1 && !reg_wdata[EP1_IN_UNDERRUN_BIT])
            i_under_reg <= 1'b0;
         if (usb_evt.ep1_in_token && in_iso && !i_rdy_reg)
            i_drop_next_reg <= 1'b1;
         else if (fifo_evt.ep1_load_full_packet || i_rdy_manual)
            i_drop_next_reg <= 1'b0;
         if (in_flush_go)
            i_flush_reg <= 1'b0;
         else if (wr_ep1 && reg_wdata[EP1_IFLUSH_BIT])
            i_flush_reg <= 1'b1;
         if (wr_ep1)
            i_ep0_send_stall_reg <= reg_wdata[EP1_ISEND_STALL_BIT];
         if (in_stall_hit)
            i_ep0_sent_stall_reg <= 1'b1;
         else if (wr_ep1 && !reg_wdata[EP1_ISENT_STALL_BIT])
            i_ep0_sent_stall_reg <= 1'b0;
      end

   assign ep1_int_next = (i_rdy_reg && (usb_evt.ep1_in_sent || in_stall_hit || in_flush_go)) ||
      o_flush_reg || usb_evt.ep1_out_stalled || (usb_evt.ep1_in_token && in_iso && !i_rdy_reg);

   // data toggles flip on each good packet; clear-toggle writes restart at DATA0
   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
      begin
         ep1_out_toggle <= 1'b0;
         ep1_in_toggle <= 1'b0;
      end
      else
      begin
         if (wr_ep1 && reg_wdata[EP1_OUT_CLEAR_TOGGLE_BIT])
            ep1_out_toggle <= 1'b0;
         else if (usb_evt.ep1_out_loaded)
            ep1_out_toggle <= !ep1_out_toggle;
         if (wr_ep1 && reg_wdata[EP1_IN_CLEAR_TOGGLE_BIT])
            ep1_in_toggle <= 1'b0;
         else if (usb_evt.ep1_in_sent)
            ep1_in_toggle <= !ep1_in_toggle;
      end

   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
      begin
         ep1_interrupt <= 1'b0;
         ep1_stall_answer <= 1'b0;
         ep1_fifo_flush <= 1'b0;
         ep1_in_write_blocked <= 1'b0;
         ep1_send_zero_length <= 1'b0;
      end
      else
      begin
         ep1_interrupt <= ep1_int_next;
         ep1_stall_answer <= is_out ? o_ep0_send_stall_reg : i_ep0_send_stall_reg;
         ep1_fifo_flush <= o_flush_reg || in_flush_go ||
            (i_drop_next_reg && fifo_evt.ep1_load_full_packet);
         ep1_in_write_blocked <= i_rdy_reg;
         ep1_send_zero_length <= usb_evt.ep1_in_token && in_iso && !i_rdy_reg;
      end

   // read port
   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
         reg_rdata <= '0;
      else if (reg_read)
         case (reg_addr)
            DISC_TIMER_ADDR: reg_rdata <= {(disc_state_reg != DISC_IDLE), 8'h00, disconnect_count_reg};
            EP0_STATUS_ADDR: reg_rdata <= {2'b00, ep0_ep0_send_stall_reg, ep0_ep0_setup_end_reg, ep0_ep0_data_end_reg,
               ep0_sstall_reg, ep0_ep0_in_ready_reg, ep0_ep0_out_ready_reg, 20'h00000, ep0_max_packet_code_reg};
            EP1_STATUS_ADDR: reg_rdata <= {2'b00, i_ep0_sent_stall_reg, i_ep0_send_stall_reg, i_flush_reg, i_under_reg,
               i_nemp_reg, i_rdy_reg, 1'b0, o_ep0_sent_stall_reg, o_ep0_send_stall_reg, o_flush_reg, o_derr_reg,
               o_over_reg, o_full_reg, o_rdy_reg, 3'b000, ep1_mode_reg, 5'h00, ep1_max_packet_code_reg};
            default: reg_rdata <= '0;
         endcase
      else
         reg_rdata <= '0;

   property p_se0_follows_run;
      @(posedge clk_sys) disable iff (reset) (disc_state_reg == DISC_RUN) |=> line_se0;
   endproperty
   a_se0_follows_run: assert property (p_se0_follows_run) else $error("se0 not driven during disconnect");

   property p_done_sets;
      @(posedge clk_sys) disable iff (reset) (disc_state_reg == DISC_DONE) |=> disconnect_done_flag;
   endproperty
   a_done_sets: assert property (p_done_sets) else $error("done flag missing");

   property p_ep0_ep0_out_ready;
      @(posedge clk_sys) disable iff (reset) usb_evt.ep0_out_received |=> ep0_ep0_out_ready_reg && ep0_int_reg;
   endproperty
   a_ep0_ep0_out_ready: assert property (p_ep0_ep0_out_ready) else $error("ep0 out-ready not set");

   property p_max_packet_code_hold;
      @(posedge clk_sys) disable iff (reset) (wr_ep0 && !reg_wdata[MAX_PACKET_CODE_SET_BIT]) |=> $stable(ep0_max_packet_code_reg);
   endproperty
   a_max_packet_code_hold: assert property (p_max_packet_code_hold) else $error("ep0 max-packet changed without enable");

   property p_ep0_setup_end;
      @(posedge clk_sys) disable iff (reset) (usb_evt.ep0_transfer_end && !ep0_ep0_data_end_reg) |=> ##1 ep0_fifo_blocked;
   endproperty
   a_ep0_setup_end: assert property (p_ep0_setup_end) else $error("setup end not blocking fifo");

   property p_in_stall_refuse;
      @(posedge clk_sys) disable iff (reset) (i_ep0_send_stall_reg && !i_rdy_reg) |=> !i_rdy_reg;
   endproperty
   a_in_stall_refuse: assert property (p_in_stall_refuse) else $error("in-ready set under send-stall");

   property p_underrun;
      @(posedge clk_sys) disable iff (reset)
         (usb_evt.ep1_in_token && in_iso && !i_rdy_reg) |=> ep1_send_zero_length && i_under_reg;
   endproperty
   a_underrun: assert property (p_underrun) else $error("underrun not flagged");

   property p_oflush_self_clear;
      @(posedge clk_sys) disable iff (reset) $rose(o_flush_reg) |=> !o_flush_reg && ep1_fifo_flush;
   endproperty
   a_oflush_self_clear: assert property (p_oflush_self_clear) else $error("out flush did not complete");

   property p_toggle_clear;
      @(posedge clk_sys) disable iff (reset) (wr_ep1 && reg_wdata[EP1_IN_CLEAR_TOGGLE_BIT]) |=> !ep1_in_toggle;
   endproperty
   a_toggle_clear: assert property (p_toggle_clear) else $error("in toggle not cleared");
endmodule // uecs_top
`default_nettype wire

// *** test/uecs_host_model.sv ***
// usb host model: pulses serial-engine events into the block
`timescale 1ns/1ps
`default_nettype none
module uecs_host_model (
   input wire logic clk_sys, // system clock
   output var uecs_pkg::uecs_evt_t evt // event pulses, one cycle each
);
   import uecs_pkg::*;
   initial evt = '0;
   // idx 0 is the msb field of the event struct
   task automatic pulse(input int idx);
      @(posedge clk_sys);
      evt <= uecs_evt_t'(12'h800 >> idx);
      @(posedge clk_sys);
      evt <= '0;
   endtask
endmodule // uecs_host_model
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the endpoint status registers and disconnect engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import uecs_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [31:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic line_se0, done_flag, ep0_stall, ep0_int, ep0_blocked;
   uecs_evt_t evt;
   uecs_fifo_t fifo_evt = '0;
   int n_fail = 0;
   int comparisons = 0;
   always #5 clk_sys = ~clk_sys;
   uecs_host_model i_uecs_host_model (.clk_sys(clk_sys), .evt(evt));
   uecs_top i_uecs_top (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .usb_evt(evt), .fifo_evt(fifo_evt),
      .line_se0(line_se0), .disconnect_done_flag(done_flag), .control_endpoint_interrupt_flag(ep0_int),
      .ep1_interrupt(), .ep0_stall_answer(ep0_stall), .ep1_stall_answer(), .ep0_fifo_flush(),
      .ep0_fifo_blocked(ep0_blocked), .ep1_fifo_flush(), .ep1_in_write_blocked(), .ep1_send_zero_length(),
      .ep1_out_toggle(), .ep1_in_toggle());
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rc(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic close_out();
      if (n_fail == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #200000;
      n_fail++;
      close_out();
   end
   initial
   begin
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      rc(DISC_TIMER_ADDR, DISC_TIMER_RESET);
      rc(EP0_STATUS_ADDR, EP0_STATUS_RESET);
      rc(EP1_STATUS_ADDR, EP1_STATUS_RESET);
      rc(32'hF00E0030, 32'h00000000);
      wr(EP0_STATUS_ADDR, 32'h00000005);
      rc(EP0_STATUS_ADDR, 32'h00000001);
      wr(EP0_STATUS_ADDR, 32'h00000088);
      rc(EP0_STATUS_ADDR, 32'h00000008);
      wr(EP1_STATUS_ADDR, 32'h00000B04);
      rc(EP1_STATUS_ADDR, 32'h00000401);
      wr(EP1_STATUS_ADDR, 32'h00008B04);
      rc(EP1_STATUS_ADDR, 32'h00000B01);
      wr(EP1_STATUS_ADDR, 32'h00008400);
      wr(EP1_STATUS_ADDR, 32'h10000000);
      wr(EP1_STATUS_ADDR, 32'h11000000);
      rc(EP1_STATUS_ADDR, 32'h10000401);
      wr(EP1_STATUS_ADDR, 32'h00000000);
      wr(EP1_STATUS_ADDR, 32'h01000000);
      rc(EP1_STATUS_ADDR, 32'h01000401);
      i_uecs_host_model.pulse(9);
      rc(EP1_STATUS_ADDR, 32'h00000401);
      // auto-set: a full packet loaded by the processor raises in-ready by itself
      wr(EP1_STATUS_ADDR, 32'h00009400);
      @(posedge clk_sys);
      fifo_evt <= uecs_fifo_t'(4'h2);
      @(posedge clk_sys);
      fifo_evt <= '0;
      rc(EP1_STATUS_ADDR, 32'h01001401);
      i_uecs_host_model.pulse(9);
      wr(EP1_STATUS_ADDR, 32'h00008C00);
      i_uecs_host_model.pulse(10);
      rc(EP1_STATUS_ADDR, 32'h04000C01);
      wr(EP1_STATUS_ADDR, 32'h00008000);
      i_uecs_host_model.pulse(4);
      rc(EP1_STATUS_ADDR, 32'h00010001);
      wr(EP1_STATUS_ADDR, 32'h00110000);
      rc(EP1_STATUS_ADDR, 32'h00000001);
      i_uecs_host_model.pulse(0);
      #1 chk({31'h0, ep0_int}, 32'h1);
      rc(EP0_STATUS_ADDR, 32'h01000008);
      chk({31'h0, ep0_int}, 32'h0);
      wr(EP0_STATUS_ADDR, 32'h40000000);
      rc(EP0_STATUS_ADDR, 32'h00000008);
      wr(EP0_STATUS_ADDR, 32'h02000000);
      i_uecs_host_model.pulse(1);
      rc(EP0_STATUS_ADDR, 32'h00000008);
      i_uecs_host_model.pulse(2);
      rc(EP0_STATUS_ADDR, 32'h04000008);
      wr(EP0_STATUS_ADDR, 32'h20000000);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, ep0_stall}, 32'h1);
      wr(EP0_STATUS_ADDR, 32'h00000000);
      wr(EP0_STATUS_ADDR, 32'h0A000000);
      rc(EP0_STATUS_ADDR, 32'h0A000008);
      i_uecs_host_model.pulse(3);
      rc(EP0_STATUS_ADDR, 32'h02000008);
      // transfer ends again with data-end clear: setup-end and fifo lockout
      i_uecs_host_model.pulse(3);
      rc(EP0_STATUS_ADDR, 32'h12000008);
      chk({31'h0, ep0_blocked}, 32'h1);
      wr(EP0_STATUS_ADDR, 32'h80000000);
      i_uecs_host_model.pulse(1);
      rc(EP0_STATUS_ADDR, 32'h00000008);
      // count 0 lasts 2^7 ticks of two clocks; registers stay untouched meanwhile
      wr(DISC_TIMER_ADDR, 32'h80000000);
      repeat (200) @(posedge clk_sys);
      chk({30'h0, line_se0, done_flag}, 32'h2);
      repeat (80) @(posedge clk_sys);
      chk({30'h0, line_se0, done_flag}, 32'h1);
      wr(DISC_TIMER_ADDR, 32'h007FFFFF);
      rc(DISC_TIMER_ADDR, 32'h007FFFFF);
      close_out();
   end
endmodule // tb_top
`default_nettype wire
